//--- rbl_pkg.sv
// shared constants and types for the reset boot loader
`default_nettype none
package rbl_pkg;
   // bus and word widths, fifo depth and vector count
   localparam int ADDR_BITS   = 24;
   localparam int WORD_BITS   = 32;
   localparam int FIFO_DEPTH  = 32;
   localparam int VEC_COUNT   = 63;
   // boot region start addresses
   localparam logic [23:0] BOOT1_BASE  = 24'h001000;
   localparam logic [23:0] BOOT2_BASE  = 24'h400000;
   localparam logic [23:0] BOOT3_BASE  = 24'hfff000;
   // vector table and loader stack locations
   localparam logic [23:0] VECTOR_BASE = 24'h809fc1;
   localparam logic [23:0] STACK_ADDR  = 24'h809801;
   // width codes found in the first header entry
   localparam logic [7:0]  WID_CODE_8  = 8'h08;
   localparam logic [7:0]  WID_CODE_16 = 8'h10;
   localparam logic [7:0]  WID_CODE_32 = 8'h20;
   // header entry index
   localparam logic [2:0]  ENT_WIDTH   = 3'h0;
   localparam logic [2:0]  ENT_CFG     = 3'h1;
   localparam logic [2:0]  ENT_COUNT   = 3'h2;
   localparam logic [2:0]  ENT_DEST    = 3'h3;
   localparam logic [2:0]  ENT_CODE    = 3'h4;
   // serial word bit count, last bit index
   localparam logic [4:0]  SER_LAST    = 5'h1f;
   // synchroniser idle values: boot sel, irq3..0, sclk, fsync, sdata
   localparam logic [7:0]  SYNC_INIT   = 8'h78;
   // start state waits this many cycles plus one for the strap to settle
   localparam logic [1:0]  SETTLE_LAST = 2'h2;
   // sequencer states
   typedef enum logic [2:0] {
      ST_START, ST_POLL, ST_FETCH, ST_DRAIN, ST_BRANCH, ST_DONE, ST_NORMAL
   } rbl_state_type;
   // boot memory width
   typedef enum logic [1:0] {WID_8, WID_16, WID_32} rbl_width_type;
endpackage
`default_nettype wire

//--- rbl_fifo.sv
// word fifo between the loader and the memory write port
`default_nettype none
module rbl_fifo
#(
   parameter int WIDTH = 56,
   parameter int DEPTH = 32
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // storage
   logic [PW:0]      wr_ptr_reg;    // write pointer with wrap bit
   logic [PW:0]      rd_ptr_reg;    // read pointer with wrap bit
   logic             push;
   logic             pop;

   // full when pointers differ only in wrap bit
   assign in_ready  = !((wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                        (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]));
   assign out_valid = (wr_ptr_reg != rd_ptr_reg);
   assign out_data  = mem[rd_ptr_reg[PW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage write
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg[PW-1:0]] <= in_data;
      end
   end

   // pointer update
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- rbl_loader.sv
// reset boot loader: mode poll, header parse, block copy and branch
// Operation
// - loader runs only when boot select high
// - poll four interrupt flags in fixed order
// - flags 0,1,2 pick three parallel regions
// - flag 3 picks serial load on port 0
// - parallel image opens with four header entries
// - first entry codes width 8, 16, 32
// - nonzero word count, 24-bit destination address
// - every parallel entry assembled as 32 bits, low first
// - copy counted words to consecutive destinations
// - successive blocks each carry count and destination
// - zero count ends load, branch to first
// - serial receive fixed 32-bit frame-synced bursts
// - serial image starts at count entry
// - vectors map into last 63 RAM words
// - stack word at fixed address stays unwritten
// - interrupt flags stay set after loading
`default_nettype none
module rbl_loader
#(
   parameter int FIFO_DEPTH = rbl_pkg::FIFO_DEPTH
)
(
   // clock and reset
   input  wire logic                          CLK,
   input  wire logic                          RST_B,
   // strap and interrupt pins, all asynchronous
   input  wire logic                          BOOT_SELECT_PIN,
   input  wire logic                          EXT_IRQ_ZERO_B,
   input  wire logic                          EXT_IRQ_ONE_B,
   input  wire logic                          EXT_IRQ_TWO_B,
   input  wire logic                          EXT_IRQ_THREE_B,
   // interrupt flag view and clear
   input  wire logic                          FLAG_CLEAR,
   output logic [3:0]                         IRQ_FLAGS,
   output logic                               LOADER_MODE,
   // boot memory read port
   output logic                               MEM_RD_REQ,
   output logic [rbl_pkg::ADDR_BITS-1:0]      MEM_RD_ADDR,
   input  wire logic                          MEM_RD_ACK,
   input  wire logic [rbl_pkg::WORD_BITS-1:0] MEM_RD_DATA,
   output logic [rbl_pkg::WORD_BITS-1:0]      BUS_CFG,
   // serial receive pins
   input  wire logic                          SER_CLK,
   input  wire logic                          RECEIVE_FRAME_SYNC,
   input  wire logic                          SER_DATA,
   output logic                               SER_OVERRUN,
   // loaded word write port
   output logic                               WR_VALID,
   output logic [rbl_pkg::ADDR_BITS-1:0]      WR_ADDR,
   output logic [rbl_pkg::WORD_BITS-1:0]      WR_DATA,
   input  wire logic                          WR_READY,
   output logic                               STACK_HIT,
   // vector lookup
   input  wire logic [5:0]                    VEC_INDEX,
   output logic [rbl_pkg::ADDR_BITS-1:0]      VECTOR_ADDR,
   // completion
   output logic                               BRANCH_VALID,
   output logic [rbl_pkg::ADDR_BITS-1:0]      BRANCH_ADDR,
   output logic                               BOOT_DONE
);
   import rbl_pkg::*;

   logic          rst_meta_reg;   // reset synchroniser stage one
   logic          rst_n;          // released reset for the design
   logic [7:0]    pins;           // raw pins into the synchroniser
   logic [1:0]    settle_reg;     // synchroniser fill count at start
   logic [7:0]    sync1_reg;      // pin synchroniser stage one
   logic [7:0]    sync2_reg;      // pin synchroniser stage two
   logic          boot_sel_s;     // synced boot select
   logic [3:0]    irq_b_s;        // synced interrupt lines
   logic [3:0]    irq_prev_reg;   // previous irq level
   logic          sclk_s;         // synced serial clock
   logic          fsync_s;        // synced frame sync
   logic          sdata_s;        // synced serial data
   logic          sclk_prev_reg;  // previous serial clock
   logic          ser_rise;       // serial clock rising edge
   logic          ser_active_reg; // serial word in progress
   logic [4:0]    ser_cnt_reg;    // bits taken in this word
   logic [31:0]   ser_shift_reg;  // serial shift register
   logic          ser_vld_reg;    // serial word ready pulse
   logic [31:0]   ser_word_reg;   // last complete serial word
   rbl_state_type st_reg;         // sequencer state
   logic          ser_mode_reg;   // serial load chosen
   logic [2:0]    ent_reg;        // current header entry
   rbl_width_type wid_reg;        // boot memory width
   rbl_width_type wid_now;        // width in force for this part
   logic [1:0]    part_reg;       // part within a word
   logic          part_last;      // last part of a word
   logic [31:0]   asm_reg;        // assembled low parts
   logic [31:0]   asm_next;       // word with current part merged
   logic [31:0]   piece;          // current part, zero extended
   logic [4:0]    sh;             // bit offset of current part
   logic          word_done;      // a full entry or code word
   logic [31:0]   word;           // value of that word
   logic [23:0]   count_reg;      // words left in block
   logic [23:0]   dst_reg;        // next destination address
   logic [23:0]   first_reg;      // first block destination
   logic          first_seen_reg; // first block header taken
   logic          fifo_in_valid;  // push a loaded word
   logic          fifo_in_ready;  // room in the fifo
   logic [55:0]   fifo_out_data;  // address and data out

   // reset release through two flops
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // pins gathered in synchroniser bit order
   assign pins = {BOOT_SELECT_PIN, EXT_IRQ_THREE_B, EXT_IRQ_TWO_B,
                  EXT_IRQ_ONE_B, EXT_IRQ_ZERO_B, SER_CLK,
                  RECEIVE_FRAME_SYNC, SER_DATA};

   // two flop synchroniser per pin
   for (genvar i = 0; i < 8; i++)
   begin : g_sync
      always_ff @(posedge CLK or negedge rst_n)
      begin
         if (!rst_n)
         begin
            sync1_reg[i] <= SYNC_INIT[i];
            sync2_reg[i] <= SYNC_INIT[i];
         end
         else
         begin
            sync1_reg[i] <= pins[i];
            sync2_reg[i] <= sync1_reg[i];
         end
      end
   end
   assign boot_sel_s = sync2_reg[7];
   assign irq_b_s    = sync2_reg[6:3];
   assign sclk_s     = sync2_reg[2];
   assign fsync_s    = sync2_reg[1];
   assign sdata_s    = sync2_reg[0];
   assign ser_rise   = sclk_s && !sclk_prev_reg;

   // interrupt flags: set on falling line, cleared only by software
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_prev_reg <= 4'hf;
         IRQ_FLAGS    <= 4'h0;
      end
      else
      begin
         irq_prev_reg <= irq_b_s;
         // set beats clear; loader itself never clears
         IRQ_FLAGS <= (FLAG_CLEAR ? 4'h0 : IRQ_FLAGS) |
                      (irq_prev_reg & ~irq_b_s);
      end
   end

   // serial receiver: 32-bit burst opened by frame sync
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_prev_reg  <= 1'b0;
         ser_active_reg <= 1'b0;
         ser_cnt_reg    <= 5'h00;
         ser_shift_reg  <= 32'h0;
         ser_vld_reg    <= 1'b0;
         ser_word_reg   <= 32'h0;
      end
      else
      begin
         sclk_prev_reg <= sclk_s;
         ser_vld_reg   <= 1'b0;
         // partner drives bit clock and sync
         if (ser_mode_reg && ser_rise && (ser_active_reg || fsync_s))
         begin
            // msb arrives first, shifts upward
            ser_shift_reg <= {ser_shift_reg[30:0], sdata_s};
            ser_cnt_reg   <= ser_cnt_reg + 5'h01;
            ser_active_reg <= (ser_cnt_reg != SER_LAST);
            if (ser_cnt_reg == SER_LAST)
            begin
               ser_vld_reg  <= 1'b1;
               ser_word_reg <= {ser_shift_reg[30:0], sdata_s};
            end
         end
      end
   end

   // width decode, first part of the first entry sets it
   always_comb
   begin
      wid_now = wid_reg;
      if (ent_reg == ENT_WIDTH && part_reg == 2'h0)
      begin
         if (MEM_RD_DATA[7:0] == WID_CODE_8)
            wid_now = WID_8;
         else if (MEM_RD_DATA[7:0] == WID_CODE_16)
            wid_now = WID_16;
         else
            wid_now = WID_32;
      end
   end

   // part merge, lowest address holds least significant part
   always_comb
   begin
      case (wid_now)
         WID_8:
         begin
            piece     = {24'h0, MEM_RD_DATA[7:0]};
            sh        = {part_reg, 3'h0};
            part_last = (part_reg == 2'h3);
         end
         WID_16:
         begin
            piece     = {16'h0, MEM_RD_DATA[15:0]};
            sh        = {part_reg[0], 4'h0};
            part_last = (part_reg == 2'h1);
         end
         default:
         begin
            piece     = MEM_RD_DATA;
            sh        = 5'h00;
            part_last = 1'b1;
         end
      endcase
      asm_next = ((part_reg == 2'h0) ? 32'h0 : asm_reg) | (piece << sh);
   end

   // word source: memory parts or serial receiver
   assign word_done = (st_reg == ST_FETCH) &&
                      (ser_mode_reg ? ser_vld_reg
                       : (MEM_RD_REQ && MEM_RD_ACK && part_last));
   assign word      = ser_mode_reg ? ser_word_reg : asm_next;
   // loader stack word is never written
   assign fifo_in_valid = word_done && (ent_reg == ENT_CODE) &&
                          (dst_reg != STACK_ADDR);

   // memory read request and address walk
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         MEM_RD_REQ  <= 1'b0;
         MEM_RD_ADDR <= 24'h0;
         part_reg    <= 2'h0;
         asm_reg     <= 32'h0;
      end
      else if (st_reg == ST_POLL)
      begin
         // fixed priority flag 0 then 1 then 2
         if (IRQ_FLAGS[0])
            MEM_RD_ADDR <= BOOT1_BASE;
         else if (IRQ_FLAGS[1])
            MEM_RD_ADDR <= BOOT2_BASE;
         else if (IRQ_FLAGS[2])
            MEM_RD_ADDR <= BOOT3_BASE;
      end
      else if (MEM_RD_REQ)
      begin
         // each part at the next address
         if (MEM_RD_ACK)
         begin
            MEM_RD_REQ  <= 1'b0;
            MEM_RD_ADDR <= MEM_RD_ADDR + 24'h1;
            part_reg    <= part_last ? 2'h0 : part_reg + 2'h1;
            asm_reg     <= asm_next;
         end
      end
      else if (st_reg == ST_FETCH && !ser_mode_reg)
      begin
         // stall code word reads while the fifo is full; header reads go ahead
         MEM_RD_REQ <= (ent_reg != ENT_CODE) || fifo_in_ready;
      end
   end

   // sequencer and header parse
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg         <= ST_START;
         settle_reg     <= 2'h0;
         LOADER_MODE    <= 1'b0;
         ser_mode_reg   <= 1'b0;
         ent_reg        <= ENT_WIDTH;
         wid_reg        <= WID_32;
         BUS_CFG        <= 32'h0;
         count_reg      <= 24'h0;
         dst_reg        <= 24'h0;
         first_reg      <= 24'h0;
         first_seen_reg <= 1'b0;
         BRANCH_VALID   <= 1'b0;
         BRANCH_ADDR    <= 24'h0;
         BOOT_DONE      <= 1'b0;
      end
      else
      begin
         BRANCH_VALID <= 1'b0;
         case (st_reg)
            ST_START:
            begin
               // wait until the strap has crossed both sync flops
               settle_reg <= settle_reg + 2'h1;
               if (settle_reg == SETTLE_LAST)
               begin
                  // strap caught after release later changes ignored
                  LOADER_MODE <= boot_sel_s;
                  st_reg      <= boot_sel_s ? ST_POLL : ST_NORMAL;
               end
            end
            ST_POLL:
            begin
               // single flag expected from partner
               if (IRQ_FLAGS[2:0] != 3'h0)
               begin
                  ent_reg <= ENT_WIDTH;
                  st_reg  <= ST_FETCH;
               end
               else if (IRQ_FLAGS[3])
               begin
                  ser_mode_reg <= 1'b1;
                  ent_reg      <= ENT_COUNT;
                  st_reg       <= ST_FETCH;
               end
            end
            ST_FETCH:
            begin
               // width code rules the later parts of its own entry
               if (ent_reg == ENT_WIDTH && part_reg == 2'h0 &&
                   MEM_RD_REQ && MEM_RD_ACK)
                  wid_reg <= wid_now;
               if (word_done)
               begin
                  case (ent_reg)
                     ENT_WIDTH:
                     begin
                        wid_reg <= wid_now;
                        ent_reg <= ENT_CFG;
                     end
                     ENT_CFG:
                     begin
                        BUS_CFG <= word;
                        ent_reg <= ENT_COUNT;
                     end
                     ENT_COUNT:
                     begin
                        count_reg <= word[23:0];
                        // zero count ends the load first zero
                        if (word == 32'h0)
                           st_reg <= ST_DRAIN;
                        else
                           ent_reg <= ENT_DEST;
                     end
                     ENT_DEST:
                     begin
                        dst_reg <= word[23:0];
                        ent_reg <= ENT_CODE;
                        if (!first_seen_reg)
                        begin
                           first_reg      <= word[23:0];
                           first_seen_reg <= 1'b1;
                        end
                     end
                     default:
                     begin
                        // consecutive destinations
                        dst_reg   <= dst_reg + 24'h1;
                        count_reg <= count_reg - 24'h1;
                        // next block header follows
                        if (count_reg == 24'h1)
                           ent_reg <= ENT_COUNT;
                     end
                  endcase
               end
            end
            ST_DRAIN:
            begin
               // branch only after every word is written
               if (!WR_VALID)
                  st_reg <= ST_BRANCH;
            end
            ST_BRANCH:
            begin
               BRANCH_VALID <= 1'b1;
               BRANCH_ADDR  <= first_reg;
               BOOT_DONE    <= 1'b1;
               st_reg       <= ST_DONE;
            end
            ST_NORMAL:
            begin
               BOOT_DONE <= 1'b1;
            end
            default:
            begin
               st_reg <= ST_DONE;
            end
         endcase
      end
   end

   // sticky status: stack hit and lost serial words
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         STACK_HIT   <= 1'b0;
         SER_OVERRUN <= 1'b0;
      end
      else
      begin
         if (word_done && ent_reg == ENT_CODE && dst_reg == STACK_ADDR)
            STACK_HIT <= 1'b1;
         if (fifo_in_valid && !fifo_in_ready)
            SER_OVERRUN <= 1'b1;
      end
   end

   // vector slots in the last words of RAM
   assign VECTOR_ADDR = (VEC_INDEX < 6'(VEC_COUNT))
                        ? VECTOR_BASE + {18'h0, VEC_INDEX}
                        : VECTOR_BASE;

   // loaded words queue towards the memory write port
   rbl_fifo #(.WIDTH(56), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk       (CLK),
      .rst_n     (rst_n),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   ({dst_reg, word}),
      .out_valid (WR_VALID),
      .out_ready (WR_READY),
      .out_data  (fifo_out_data)
   );
   assign WR_ADDR = fifo_out_data[55:32];
   assign WR_DATA = fifo_out_data[31:0];

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   normal_mode_a: assert property (
      st_reg == ST_NORMAL |-> !MEM_RD_REQ && !LOADER_MODE ##1 BOOT_DONE)
      else $error("normal start touched boot memory");
   poll_order_a: assert property (
      st_reg == ST_POLL && IRQ_FLAGS[0] |=> MEM_RD_ADDR == BOOT1_BASE)
      else $error("flag zero did not pick first region");
   region_two_a: assert property (
      st_reg == ST_POLL && IRQ_FLAGS[2:0] == 3'h4
         |=> MEM_RD_ADDR == BOOT3_BASE && !ser_mode_reg)
      else $error("flag two did not pick third region");
   serial_pick_a: assert property (
      st_reg == ST_POLL && IRQ_FLAGS == 4'h8
         |=> ser_mode_reg && ent_reg == ENT_COUNT)
      else $error("flag three did not pick serial load");
   part_addr_a: assert property (
      MEM_RD_REQ && MEM_RD_ACK |=> MEM_RD_ADDR == $past(MEM_RD_ADDR) + 24'h1)
      else $error("part address did not advance");
   byte_order_a: assert property (
      fifo_in_valid && !ser_mode_reg && wid_reg == WID_8
         |-> word[31:24] == MEM_RD_DATA[7:0])
      else $error("last byte not placed high");
   copy_addr_a: assert property (
      word_done && ent_reg == ENT_CODE |=> dst_reg == $past(dst_reg) + 24'h1)
      else $error("destination did not advance");
   zero_count_a: assert property (
      word_done && ent_reg == ENT_COUNT && word == 32'h0
         |=> st_reg == ST_DRAIN)
      else $error("zero count did not end the load");
   branch_done_a: assert property (
      BRANCH_VALID |-> BRANCH_ADDR == first_reg && !WR_VALID ##1 BOOT_DONE)
      else $error("branch not to first block");
   stack_keep_a: assert property (
      WR_VALID |-> WR_ADDR != STACK_ADDR)
      else $error("stack word written");
   flag_keep_a: assert property (
      !$past(FLAG_CLEAR) |-> (IRQ_FLAGS & $past(IRQ_FLAGS)) == $past(IRQ_FLAGS))
      else $error("interrupt flag lost");
   ser_len_a: assert property (
      ser_vld_reg |-> $past(ser_cnt_reg) == SER_LAST && !ser_active_reg)
      else $error("serial word not 32 bits");

   par_boot_c: cover property (BRANCH_VALID && !ser_mode_reg);
   ser_boot_c: cover property (BRANCH_VALID && ser_mode_reg);
   byte_boot_c: cover property (fifo_in_valid && wid_reg == WID_8);
   normal_c: cover property (st_reg == ST_NORMAL);
endmodule
`default_nettype wire

//--- rbl_mem_model.sv
// boot memory model answering the loader's read port
`default_nettype none
module rbl_mem_model
(
   // clock and stall control
   input  wire logic        clk,
   input  wire logic        slow,
   // read port
   input  wire logic        req,
   input  wire logic [23:0] addr,
   output logic             ack,
   output logic [31:0]      data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:63];  // byte image from region base
   initial ack = 1'b0;
   initial data = 32'h0;
   // one ack per request, late when slow; a byte part floats the top
   always @(posedge clk)
   begin
      if (req && !ack && !slow)
      begin
         ack  <= 1'b1;
         data <= {24'hffffff, mem[addr[5:0]]};
      end
      else
      begin
         ack  <= 1'b0;
         data <= ~data;  // released bus keeps no stale value
      end
   end
endmodule
`default_nettype wire

//--- rbl_loader_tb_top.sv
// testbench: byte-wide parallel load, then serial load
`default_nettype none
module rbl_loader_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_b, ack, slow, rdy, sclk, fsync, sdat, done;
   logic        req, wr_v, br_v, mode, bsel, clr, hit, ovr;
   logic [11:0] region;  // expected top bits of read addresses
   logic [3:0]  irq_b, flags;
   logic [5:0]  vec;
   logic [23:0] rd_a, wr_a, br_a, vec_a, first_dest;
   logic [31:0] rd_d, wr_d, cfg, cfg_seen, w;
   logic [55:0] exp_q[$];  // expected {address, word} writes
   integer      err_count, compares, seed, cyc, i, ln;
   rbl_mem_model mdl (.clk(clk), .slow(slow), .req(req), .addr(rd_a),
      .ack(ack), .data(rd_d));
   rbl_loader dut (.CLK(clk), .RST_B(rst_b), .BOOT_SELECT_PIN(bsel),
      .EXT_IRQ_ZERO_B(irq_b[0]), .EXT_IRQ_ONE_B(irq_b[1]),
      .EXT_IRQ_TWO_B(irq_b[2]), .EXT_IRQ_THREE_B(irq_b[3]),
      .FLAG_CLEAR(clr), .IRQ_FLAGS(flags), .LOADER_MODE(mode),
      .MEM_RD_REQ(req), .MEM_RD_ADDR(rd_a), .MEM_RD_ACK(ack),
      .MEM_RD_DATA(rd_d), .BUS_CFG(cfg_seen), .SER_CLK(sclk),
      .RECEIVE_FRAME_SYNC(fsync), .SER_DATA(sdat), .SER_OVERRUN(ovr),
      .WR_VALID(wr_v), .WR_ADDR(wr_a), .WR_DATA(wr_d), .WR_READY(rdy),
      .STACK_HIT(hit), .VEC_INDEX(vec), .VECTOR_ADDR(vec_a),
      .BRANCH_VALID(br_v), .BRANCH_ADDR(br_a), .BOOT_DONE(done));
   task automatic check(input logic [55:0] seen, exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one 32-bit entry as four bytes, low byte first
   task automatic put(input int idx, input logic [31:0] v);
      for (int b = 0; b < 4; b++)
         mdl.mem[idx*4+b] = v[b*8+:8];
   endtask
   // framed word, msb first; bit clock idles low outside frames
   task automatic ser_word(input logic [31:0] v);
      for (int b = 31; b >= 0; b--)
      begin
         fsync = (b == 31);
         sdat = v[b];
         #100 sclk = 1'b1;
         #100 sclk = 1'b0;
      end
      fsync = 1'b0;
      sdat = ~sdat;
   endtask
   // reset with the strap set, then one mode line falls
   task automatic boot(input int line, input logic sel);
      #2 rst_b = 1'b0;
      irq_b = 4'hf;
      bsel = sel;
      repeat (2) @(posedge clk);
      #2 rst_b = 1'b1;
      repeat (8) @(posedge clk);
      #2 irq_b[line] = 1'b0;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // random stalls and vector index, just after each edge
   always @(posedge clk)
      #2 {vec, rdy, slow} = 8'($random(seed));
   // watcher: compares every write, branch and vector lookup
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         err_count++;
         conclude();
      end
      if (wr_v && rdy)
         check({wr_a, wr_d}, exp_q.pop_front(), "write");
      if (br_v)
         check(br_a, first_dest, "branch");
      if (req)
         check(rd_a[23:12], region, "region");
      check(vec_a, 24'h809fc1 + ((vec < 63) ? vec : 0), "vector");
   end
   initial
   begin
      {err_count, compares, cyc} = 0;
      seed = 32'hd3e6;
      {rst_b, sclk, fsync, sdat, rdy, slow, clr, bsel} = 0;
      irq_b = 4'hf;
      vec = 6'h0;
      region = 12'h0;
      cfg = $random(seed);
      first_dest = 24'h809c00;
      put(0, 32'h8);
      put(1, cfg);
      put(2, 32'h2);
      put(3, 32'h809c00);
      put(6, 32'h0);
      // strap low: normal start, no boot activity
      boot(3, 1'b0);
      repeat (8) @(posedge clk);
      check({mode, done, req}, 3'b010, "normal");
      // byte-wide load from each of the three regions
      for (ln = 0; ln < 3; ln++)
      begin
         region = (ln == 0) ? 12'h001 : (ln == 1) ? 12'h400 : 12'hfff;
         for (i = 0; i < 2; i++)
         begin
            w = $random(seed);
            put(4 + i, w);
            exp_q.push_back({first_dest + 24'(i), w});
         end
         boot(ln, 1'b1);
         for (i = 0; i < 3000 && !done; i++)
            @(posedge clk);
         check(flags, 4'(1 << ln), "flags");
         check(cfg_seen, cfg, "bus_cfg");
         check(mode, 1'b1, "mode");
      end
      boot(3, 1'b1);
      first_dest = 24'h809c10;
      w = $random(seed);
      exp_q.push_back({first_dest, w});
      #7 ser_word(32'h1);
      ser_word({8'h0, first_dest});
      ser_word(w);
      ser_word(32'h1);
      ser_word(32'h809801);
      ser_word(~w);
      ser_word(32'h0);
      for (i = 0; i < 300 && !done; i++)
         @(posedge clk);
      check(flags, 4'b1000, "flags");
      check({hit, ovr}, 2'b10, "stack");
      check(exp_q.size(), 0, "pending");
      #2 clr = 1'b1;
      @(posedge clk);
      #2 clr = 1'b0;
      check(flags, 4'h0, "clear");
      conclude();
   end
endmodule
`default_nettype wire
